// ===== src/touch_pkg.sv
// constants shared by the grouped touch timing, recalibration and alert register block
package touch_pkg;

  // ***************************************************************
  // register offsets and values after reset
  // ***************************************************************
  localparam logic [7:0] ADDR_GROUP_HOLD = 8'h23;
  localparam logic [7:0] ADDR_GROUP_DUR_SLIDE = 8'h24;
  localparam logic [7:0] ADDR_AUTO_RECAL = 8'h25;
  localparam logic [7:0] ADDR_RECAL_TRIGGER = 8'h26;
  localparam logic [7:0] ADDR_TOUCH_IRQ = 8'h27;
  localparam logic [7:0] ADDR_PIN_IRQ = 8'h28;

  localparam logic [7:0] RST_GROUP_HOLD = 8'h47;
  localparam logic [7:0] RST_GROUP_DUR_SLIDE = 8'hD4;
  localparam logic [7:0] RST_AUTO_RECAL = 8'hFF;
  localparam logic [7:0] RST_RECAL_TRIGGER = 8'h00;
  localparam logic [7:0] RST_TOUCH_IRQ = 8'hFF;
  localparam logic [7:0] RST_PIN_IRQ = 8'h00;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int NIBBLE_HI_LSB = 4;
  localparam int GROUP_BIT = 7;
  localparam int NUM_CHAN = 7;
  localparam int NUM_SENSE = 14;
  localparam int ST_HOLD = 0;
  localparam int ST_TAP = 1;
  localparam int ST_DOWN = 2;
  localparam int ST_UP = 3;

  // ***************************************************************
  // timing: every millisecond figure is counted in 35 ms ticks
  // ***************************************************************
  localparam int CLK_MHZ = 100;
  localparam int TICK_MS = 35;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int RECAL_MS = 600;
  // longest blind time, rounded down to whole ticks
  localparam int RECAL_TICKS = RECAL_MS / TICK_MS;

  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_PRESS = 2'b01,
    G_HOLD = 2'b11
  } gesture_state_t;

  // press time allowed before recalibration, in ms, rounded up to ticks
  function automatic logic [8:0] max_press_ticks(input logic [3:0] code);
    int ms;
    ms = 560;
    case (code)
      4'h0: ms = 560;
      4'h1: ms = 840;
      4'h2: ms = 1120;
      4'h3: ms = 1400;
      4'h4: ms = 1680;
      4'h5: ms = 2240;
      4'h6: ms = 2800;
      4'h7: ms = 3360;
      4'h8: ms = 3920;
      4'h9: ms = 4480;
      4'hA: ms = 5600;
      4'hB: ms = 6720;
      4'hC: ms = 7840;
      4'hD: ms = 8906;
      4'hE: ms = 10080;
      default: ms = 11200;
    endcase
    return 9'((ms + TICK_MS - 1) / TICK_MS);
  endfunction

endpackage

// ===== src/recal_unit.sv
// one recalibration sequencer: a touch-free window of fixed length per sensor or group
`timescale 1ns/1ps
module recal_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic start,
  input wire logic touched,
  output logic busy,
  output logic done
);

  logic [4:0] cnt;

  // a touch inside the window spoils the baseline, so the window starts over
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 5'h00;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!busy)
      begin
        if (start)
        begin
          busy <= 1'b1;
          cnt <= 5'h00;
        end
      end
      else if (touched)
        cnt <= 5'h00; // RULE15
      else if (tick)
      begin
        if (cnt == 5'(touch_pkg::RECAL_TICKS - 1))
        begin
          busy <= 1'b0; // RULE14
          done <= 1'b1;
        end
        else
          cnt <= cnt + 5'h01;
      end
    end
  end

  a_done_full_window: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    done |-> (cnt == 5'(touch_pkg::RECAL_TICKS - 1)) && !busy)
    else $error("recalibration finished before its full window");

  a_touch_restarts: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (ce && busy && touched) |=> (cnt == 5'h00) && busy && !done)
    else $error("touch during recalibration did not restart it");

endmodule

// ===== src/touch_group_cal_irq_regs.sv
// grouped slider timing, recalibration control and alert enables of the touch controller
// ***************************************************************
// How it works
// (RULE1) upper nibble of 23h sets press-and-hold repeat interval, resets 0100b
// (RULE2) four-bit interval codes decode as (code+1) times 35 ms
// (RULE3) group touch longer than lower nibble of 23h reports press-and-hold, resets 0111b
// (RULE4) group touch no longer than that threshold reports a tap
// (RULE5) slides are flagged on their own, independent of hold threshold
// (RULE6) 24h timings apply only to channels 8 to 14, the group
// (RULE7) upper nibble of 24h picks longest group press before recalibration, resets 1101b
// (RULE8) that code decodes through the 560 to 11200 ms table
// (RULE9) with checking on, a press past that time restarts group recalibration
// (RULE10) lower nibble of 24h is slide repeat base, scaled by speed, resets 0100b
// (RULE11) 25h bits allow auto recalibration per channel, ignored if sensor off
// (RULE12) 25h bit 7 clear stops group auto recalibration, manual trigger still works
// (RULE13) writing one to 26h starts recalibration, hardware clears bit when done
// (RULE14) recalibrating sensors report no presses and their base counts are invalid
// (RULE15) a touch during recalibration spoils that attempt
// (RULE16) group trigger clears only after the whole group recalibrated cleanly
// (RULE17) 27h bit 7 gates alert for group slide, tap and hold flags
// (RULE18) 27h bits 6 to 0 gate alert for touches on inputs seven to one
// (RULE19) 28h bits gate alert for general-purpose input flags eight to one
// (RULE20) alert drives whenever an enabled flag is set; timing from one tick
// ***************************************************************
`timescale 1ns/1ps
module touch_group_cal_irq_regs #(
  parameter int tick_cycles = touch_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [13:0] touch_raw,
  input wire logic [7:0] sensor_on,
  input wire logic group_max_press_check_on,
  input wire logic group_hold_repeat_on,
  input wire logic slide_up,
  input wire logic slide_down,
  input wire logic [1:0] slide_speed,
  input wire logic [6:0] chan_auto_req,
  input wire logic group_auto_req,
  input wire logic [6:0] chan_status,
  input wire logic [7:0] pin_status,
  input wire logic status_clear,
  output logic [13:0] touch_valid,
  output logic [7:0] base_invalid,
  output logic [3:0] group_status,
  output logic alert_n
);

  // ***************************************************************
  // reset release and pin synchronisers
  // ***************************************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [13:0] touch_meta;
  logic [13:0] touch_sync;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      touch_meta <= 14'h0000;
      touch_sync <= 14'h0000;
    end
    else if (ce)
    begin
      touch_meta <= touch_raw;
      touch_sync <= touch_meta;
    end
  end

  // ***************************************************************
  // common 35 ms tick
  // ***************************************************************
  logic [21:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 22'h000000;
    else if (ce)
    begin
      if (tick)
        tick_cnt <= 22'h000000; // RULE20
      else
        tick_cnt <= tick_cnt + 22'h000001;
    end
  end
  assign tick = ce && (tick_cnt == 22'(tick_cycles - 1));

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] group_hold_timing;
  logic [7:0] group_duration_slide_timing;
  logic [7:0] auto_recal_enable;
  logic [7:0] recal_trigger;
  logic [7:0] touch_irq_enable;
  logic [7:0] pin_irq_enable;
  logic [7:0] next_recal_trigger;
  logic [7:0] cal_busy;
  logic [7:0] cal_done;
  logic trig_wr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      group_hold_timing <= touch_pkg::RST_GROUP_HOLD; // RULE1 RULE3
      group_duration_slide_timing <= touch_pkg::RST_GROUP_DUR_SLIDE; // RULE7 RULE10
      auto_recal_enable <= touch_pkg::RST_AUTO_RECAL;
      touch_irq_enable <= touch_pkg::RST_TOUCH_IRQ;
      pin_irq_enable <= touch_pkg::RST_PIN_IRQ;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == touch_pkg::ADDR_GROUP_HOLD)
        group_hold_timing <= reg_wdata;
      else if (reg_addr == touch_pkg::ADDR_GROUP_DUR_SLIDE)
        group_duration_slide_timing <= reg_wdata;
      else if (reg_addr == touch_pkg::ADDR_AUTO_RECAL)
        auto_recal_enable <= reg_wdata;
      else if (reg_addr == touch_pkg::ADDR_TOUCH_IRQ)
        touch_irq_enable <= reg_wdata;
      else if (reg_addr == touch_pkg::ADDR_PIN_IRQ)
        pin_irq_enable <= reg_wdata;
    end
  end

  // writing zero cannot abort a run; a set arriving with a finish wins
  assign trig_wr = reg_wr && (reg_addr == touch_pkg::ADDR_RECAL_TRIGGER);
  assign next_recal_trigger = ({8{trig_wr}} & reg_wdata) | (recal_trigger & ~cal_done); // RULE13
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      recal_trigger <= touch_pkg::RST_RECAL_TRIGGER;
    else if (ce)
      recal_trigger <= next_recal_trigger; // RULE13 RULE16
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd)
    begin
      if (reg_addr == touch_pkg::ADDR_GROUP_HOLD)
        reg_rdata <= group_hold_timing;
      else if (reg_addr == touch_pkg::ADDR_GROUP_DUR_SLIDE)
        reg_rdata <= group_duration_slide_timing;
      else if (reg_addr == touch_pkg::ADDR_AUTO_RECAL)
        reg_rdata <= auto_recal_enable;
      else if (reg_addr == touch_pkg::ADDR_RECAL_TRIGGER)
        reg_rdata <= recal_trigger;
      else if (reg_addr == touch_pkg::ADDR_TOUCH_IRQ)
        reg_rdata <= touch_irq_enable;
      else if (reg_addr == touch_pkg::ADDR_PIN_IRQ)
        reg_rdata <= pin_irq_enable;
      else
        reg_rdata <= 8'h00;
    end
  end
  // ***************************************************************
  // recalibration: seven single channels and the group as one unit
  // ***************************************************************
  logic [6:0] chan_auto_start;
  logic grp_auto_start;
  logic maxdur_req;
  logic [7:0] unit_touched;
  logic [7:0] unit_start;
  assign chan_auto_start = chan_auto_req & auto_recal_enable[6:0] & sensor_on[6:0]; // RULE11
  assign grp_auto_start = (group_auto_req || maxdur_req) // RULE9
    && auto_recal_enable[touch_pkg::GROUP_BIT] && sensor_on[touch_pkg::GROUP_BIT]; // RULE12
  assign unit_touched = {|touch_sync[13:7], touch_sync[6:0]};
  // the trigger bit lingers one cycle after done; masking it stops a second run
  assign unit_start = (recal_trigger & ~cal_done) // RULE13
    | {grp_auto_start, chan_auto_start}; // RULE12
  // the group unit only finishes when no group channel was touched, so all pass together
  for (genvar i = 0; i < 8; i++)
  begin : g_recal
    recal_unit u_recal (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .tick(tick),
      .start(unit_start[i]),
      .touched(unit_touched[i]), // RULE16
      .busy(cal_busy[i]),
      .done(cal_done[i])
    );
  end
  assign base_invalid = cal_busy; // RULE14
  assign touch_valid = touch_sync & {{7{sensor_on[7] & ~cal_busy[7]}}, // RULE6 RULE14
    sensor_on[6:0] & ~cal_busy[6:0]};
  // ***************************************************************
  // group gestures: tap, press-and-hold, maximum press, slides
  // ***************************************************************
  touch_pkg::gesture_state_t gstate;
  logic grp_touch;
  logic [8:0] press_cnt;
  logic [4:0] rpt_cnt;
  logic [4:0] hold_thr;
  logic [4:0] hold_rpt;
  logic [4:0] slide_base;
  logic [4:0] slide_int;
  logic [4:0] slide_cnt;
  logic slide_on;
  logic slide_is_up;
  logic [8:0] max_ticks;
  logic [3:0] ev;

  assign grp_touch = |touch_valid[13:7]; // RULE6
  assign hold_thr = {1'b0, group_hold_timing[3:0]} + 5'h01; // RULE2 RULE3
  assign hold_rpt = {1'b0, group_hold_timing[7:touch_pkg::NIBBLE_HI_LSB]} + 5'h01; // RULE1 RULE2
  assign slide_base = {1'b0, group_duration_slide_timing[3:0]} + 5'h01; // RULE10
  assign slide_int = ((slide_base >> slide_speed) == 5'h00) ? 5'h01 : (slide_base >> slide_speed);
  assign max_ticks = touch_pkg::max_press_ticks( // RULE7 RULE8
    group_duration_slide_timing[7:touch_pkg::NIBBLE_HI_LSB]);
  assign maxdur_req = group_max_press_check_on && tick && grp_touch // RULE9
    && (gstate != touch_pkg::G_IDLE) && ((press_cnt + 9'h001) == max_ticks);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gstate <= touch_pkg::G_IDLE;
      press_cnt <= 9'h000;
      rpt_cnt <= 5'h00;
    end
    else if (ce)
    begin
      case (gstate)
        touch_pkg::G_IDLE:
        begin
          press_cnt <= 9'h000;
          rpt_cnt <= 5'h00;
          if (grp_touch)
            gstate <= touch_pkg::G_PRESS;
        end
        touch_pkg::G_PRESS:
        begin
          if (!grp_touch)
            gstate <= touch_pkg::G_IDLE; // RULE4
          else if (tick)
          begin
            press_cnt <= press_cnt + 9'h001;
            if ((press_cnt + 9'h001) > {4'h0, hold_thr})
              gstate <= touch_pkg::G_HOLD; // RULE3
          end
        end
        touch_pkg::G_HOLD:
        begin
          if (!grp_touch)
            gstate <= touch_pkg::G_IDLE;
          else if (tick)
          begin
            if (press_cnt != 9'h1FF)
              press_cnt <= press_cnt + 9'h001;
            rpt_cnt <= ((rpt_cnt + 5'h01) == hold_rpt) ? 5'h00 : rpt_cnt + 5'h01; // RULE1
          end
        end
        default: gstate <= touch_pkg::G_IDLE;
      endcase
    end
  end
  // slide repeats keep their direction while the finger stays on the group
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slide_on <= 1'b0;
      slide_is_up <= 1'b0;
      slide_cnt <= 5'h00;
    end
    else if (ce)
    begin
      if (slide_up || slide_down)
      begin
        slide_on <= 1'b1; // RULE5
        slide_is_up <= slide_up;
        slide_cnt <= 5'h00;
      end
      else if (!grp_touch)
        slide_on <= 1'b0;
      else if (slide_on && tick)
        slide_cnt <= ((slide_cnt + 5'h01) >= slide_int) ? 5'h00 : slide_cnt + 5'h01; // RULE10
    end
  end
  always_comb
  begin
    ev = 4'h0;
    ev[touch_pkg::ST_TAP] = (gstate == touch_pkg::G_PRESS) && !grp_touch; // RULE4
    ev[touch_pkg::ST_HOLD] = ((gstate == touch_pkg::G_PRESS) && grp_touch && tick // RULE3
      && ((press_cnt + 9'h001) > {4'h0, hold_thr}))
      || ((gstate == touch_pkg::G_HOLD) && grp_touch && tick && group_hold_repeat_on
      && ((rpt_cnt + 5'h01) == hold_rpt)); // RULE1
    ev[touch_pkg::ST_UP] = slide_up // RULE5
      || (slide_on && slide_is_up && grp_touch && tick && ((slide_cnt + 5'h01) >= slide_int));
    ev[touch_pkg::ST_DOWN] = slide_down
      || (slide_on && !slide_is_up && grp_touch && tick && ((slide_cnt + 5'h01) >= slide_int));
  end
  // ***************************************************************
  // status flags and alert
  // ***************************************************************
  logic irq_pend;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      group_status <= 4'h0;
    else if (ce)
      group_status <= (group_status & ~{4{status_clear}}) | ev; // set wins over clear
  end
  assign irq_pend = (|group_status && touch_irq_enable[touch_pkg::GROUP_BIT]) // RULE17
    || |(chan_status & touch_irq_enable[6:0]) // RULE18
    || |(pin_status & pin_irq_enable); // RULE19
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      alert_n <= 1'b1;
    else if (ce)
      alert_n <= ~irq_pend; // RULE20
  end
  // ***************************************************************
  // checks
  // ***************************************************************
  a_trigger_set: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    (ce && trig_wr && reg_wdata[7]) |=> recal_trigger[7])
    else $error("trigger write of one was lost");
  a_group_trig_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
    (ce && cal_done[7] && !(trig_wr && reg_wdata[7])) |=> !recal_trigger[7])
    else $error("group trigger did not clear after success");
  a_group_auto_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    (!auto_recal_enable[7] && !recal_trigger[7] && !cal_busy[7] && ce) |=> !cal_busy[7])
    else $error("group recalibrated without enable or trigger");
  a_chan_auto_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (ce && !recal_trigger[0] && !cal_busy[0] && !(auto_recal_enable[0] && sensor_on[0]))
    |=> !cal_busy[0])
    else $error("channel one recalibrated while auto disabled");
  a_tap_release: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    (ce && gstate == touch_pkg::G_PRESS && !grp_touch)
    |=> group_status[touch_pkg::ST_TAP] && gstate == touch_pkg::G_IDLE)
    else $error("short group touch not reported as tap");
  a_hold_enter: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    (ce && gstate == touch_pkg::G_PRESS && grp_touch && tick
    && (press_cnt + 9'h001) > {4'h0, hold_thr})
    |=> gstate == touch_pkg::G_HOLD && group_status[touch_pkg::ST_HOLD])
    else $error("press-and-hold not reported after threshold");
  a_no_touch_in_cal: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    cal_busy[7] |-> touch_valid[13:7] == 7'h00)
    else $error("group press reported during recalibration");
  a_alert_follows: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    (ce && irq_pend) |=> !alert_n)
    else $error("alert not driven for enabled flag");
  a_alert_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (ce && !irq_pend) |=> alert_n)
    else $error("alert driven with no enabled flag");
endmodule

// ===== testbench/touch_host.sv
// host-side partner: register reads and writes over the block's byte port
`timescale 1ns/1ps
module touch_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ***************************************************************
  // byte port access
  // ***************************************************************
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // writing ones here is how the host starts recalibration
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // released bus shows the inverse, so no stale byte can pass as valid
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    reg_addr = ~a;
  endtask
endmodule

// ===== testbench/touch_group_cal_irq_regs_tb.sv
// self-checking bench for the group timing, recalibration and alert registers
`timescale 1ns/1ps
`define CHK(g, e) chk(8'(g), 8'(e))
module touch_group_cal_irq_regs_tb;
  // short tick keeps the 35 ms based counts inside a small run
  localparam int TC = 20;
  logic clk, rstn, ce, reg_wr, reg_rd, gmax_on, rpt_on, sl_up, sl_dn, gauto, sclr, alert_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sensor_on, pin_status, base_invalid, v;
  logic [13:0] touch_raw, touch_valid;
  logic [6:0] cauto, chan_status;
  logic [3:0] group_status;
  logic [1:0] speed;
  int n_mismatch, check_count, n;
  logic [7:0] ad [7] = '{touch_pkg::ADDR_GROUP_HOLD, touch_pkg::ADDR_GROUP_DUR_SLIDE,
    touch_pkg::ADDR_AUTO_RECAL, touch_pkg::ADDR_RECAL_TRIGGER, touch_pkg::ADDR_TOUCH_IRQ,
    touch_pkg::ADDR_PIN_IRQ, 8'h29};
  logic [7:0] rs [7] = '{touch_pkg::RST_GROUP_HOLD, touch_pkg::RST_GROUP_DUR_SLIDE,
    touch_pkg::RST_AUTO_RECAL, touch_pkg::RST_RECAL_TRIGGER, touch_pkg::RST_TOUCH_IRQ,
    touch_pkg::RST_PIN_IRQ, 8'h00};
  logic [7:0] wv [6] = '{8'h41, 8'h04, 8'h7F, 8'h00, 8'hFF, 8'h80};

  touch_group_cal_irq_regs #(.tick_cycles(TC)) dut (
    .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .touch_raw(touch_raw),
    .sensor_on(sensor_on), .group_max_press_check_on(gmax_on),
    .group_hold_repeat_on(rpt_on), .slide_up(sl_up), .slide_down(sl_dn),
    .slide_speed(speed), .chan_auto_req(cauto), .group_auto_req(gauto),
    .chan_status(chan_status), .pin_status(pin_status), .status_clear(sclr),
    .touch_valid(touch_valid), .base_invalid(base_invalid),
    .group_status(group_status), .alert_n(alert_n)
  );

  touch_host host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_bi(input int i, input logic lvl);
    n = 0;
    while (base_invalid[i] !== lvl)
    begin
      @(negedge clk);
      n++;
      if (n > 1000)
      begin
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, base_invalid[i], lvl);
        end_sim;
      end
    end
  endtask

  task automatic clear_flags;
    sclr = 1'b1;
    cyc(1);
    sclr = 1'b0;
    cyc(2);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    rstn = 1'b0;
    ce = 1'b1;
    gmax_on = 1'b0;
    rpt_on = 1'b0;
    sl_up = 1'b0;
    sl_dn = 1'b0;
    gauto = 1'b0;
    sclr = 1'b0;
    speed = 2'h0;
    cauto = 7'h00;
    chan_status = 7'h00;
    pin_status = 8'h00;
    sensor_on = 8'hFF;
    touch_raw = 14'h0000;
    cyc(16);
    rstn = 1'b1;
    cyc(4);
    host.wr(8'h29, 8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      host.rd(ad[i], v);
      `CHK(v, rs[i]);
    end
    $display("test reset_values done");
    for (int i = 0; i < 6; i++)
    begin
      if (i != 3)
      begin
        host.wr(ad[i], wv[i]);
        host.rd(ad[i], v);
        `CHK(v, wv[i]);
      end
    end
    $display("test readback done");
    pin_status = 8'h01;
    cyc(3);
    `CHK(alert_n, 1'b1);
    pin_status = 8'h80;
    cyc(3);
    `CHK(alert_n, 1'b0);
    pin_status = 8'h00;
    chan_status = 7'h01;
    cyc(3);
    `CHK(alert_n, 1'b0);
    host.wr(8'h27, 8'hFE);
    cyc(3);
    `CHK(alert_n, 1'b1);
    chan_status = 7'h00;
    $display("test alert_gating done");
    touch_raw[7] = 1'b1;
    cyc(10);
    touch_raw[7] = 1'b0;
    cyc(30);
    `CHK(group_status, 4'h2);
    clear_flags;
    touch_raw[7] = 1'b1;
    cyc(8 * TC);
    touch_raw[7] = 1'b0;
    cyc(30);
    `CHK(group_status, 4'h1);
    clear_flags;
    sl_up = 1'b1;
    cyc(1);
    sl_up = 1'b0;
    cyc(3);
    `CHK(group_status, 4'h8);
    sl_dn = 1'b1;
    cyc(1);
    sl_dn = 1'b0;
    cyc(3);
    `CHK(group_status, 4'hC);
    host.wr(8'h27, 8'h7F);
    cyc(3);
    `CHK(alert_n, 1'b1);
    host.wr(8'h27, 8'h80);
    cyc(3);
    `CHK(alert_n, 1'b0);
    clear_flags;
    `CHK(alert_n, 1'b1);
    $display("test gestures done");
    host.wr(8'h26, 8'h01);
    cyc(2);
    `CHK(base_invalid[0], 1'b1);
    touch_raw[0] = 1'b1;
    cyc(100);
    `CHK(touch_valid[0], 1'b0);
    touch_raw[0] = 1'b0;
    wait_bi(0, 1'b0);
    `CHK(n >= 16 * TC, 1'b1);
    host.rd(8'h26, v);
    `CHK(v, 8'h00);
    touch_raw[0] = 1'b1;
    cyc(4);
    `CHK(touch_valid[0], 1'b1);
    touch_raw[0] = 1'b0;
    $display("test manual_recal done");
    sensor_on = 8'hFE;
    cauto = 7'h03;
    cyc(1);
    cauto = 7'h00;
    cyc(2);
    `CHK(base_invalid[1:0], 2'b10);
    wait_bi(1, 1'b0);
    sensor_on = 8'hFF;
    gauto = 1'b1;
    cyc(1);
    gauto = 1'b0;
    cyc(2);
    `CHK(base_invalid[7], 1'b0);
    host.wr(8'h26, 8'h80);
    cyc(2);
    `CHK(base_invalid[7], 1'b1);
    host.rd(8'h26, v);
    `CHK(v, 8'h80);
    wait_bi(7, 1'b0);
    cyc(2);
    host.rd(8'h26, v);
    `CHK(v, 8'h00);
    $display("test group_recal done");
    host.wr(8'h25, 8'hFF);
    gmax_on = 1'b1;
    touch_raw[7] = 1'b1;
    wait_bi(7, 1'b1);
    `CHK(n >= 15 * TC && n <= 17 * TC, 1'b1);
    touch_raw[7] = 1'b0;
    wait_bi(7, 1'b0);
    gmax_on = 1'b0;
    $display("test max_press done");
    // hold flag must come back at the repeat interval while the group stays pressed
    clear_flags;
    rpt_on = 1'b1;
    touch_raw[7] = 1'b1;
    cyc(5 * TC);
    clear_flags;
    cyc(5 * TC);
    `CHK(group_status, 4'h1);
    touch_raw[7] = 1'b0;
    rpt_on = 1'b0;
    cyc(30);
    $display("test hold_repeat done");
    end_sim;
  end
endmodule
